// ---- verilog/hdma_pkg.sv ----
// hdma_pkg: constants, field layout and carrier types of the hdlc descriptor memory engine
//
// Notes on behaviour
// [R1] receive descriptor: three reads, three write-backs
// [R2] transmit descriptor: three reads, two write-backs
// [R3] data words: one plus floor((n-1)/4)
// [R4] every memory access is a full word
// [R5] frames longer than buffer span descriptors
// [R6] two crc bytes added, never fetched
// [R7] hold command stops transmit memory accesses
// [R8] only a release command ends hold
// [R9] idle fill n sends n+1 characters; a fill count of 0 sends none
// [R10] no descriptor polling during idle fill
// [R11] held descriptor re-polled every slot
// [R12] normal polling once per four slots
// [R13] request bus, wait grant, one master
package hdma_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // access counts
   localparam int unsigned DESC_READS = 3;
   localparam int unsigned RX_DESC_ACCESSES = 6;
   localparam int unsigned TX_DESC_ACCESSES = 5;
   localparam int unsigned CRC_BYTES = 2;
   localparam int unsigned POLL_SLOTS = 4;
   localparam int unsigned LEN_W = 13;
   localparam int unsigned WORDS_W = 11;
   localparam int unsigned FILL_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // descriptor word offsets and memory map around the control base
   localparam logic [31:0] DESC_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_0004;
   localparam logic [31:0] DESC_BUF_OFS = 32'h0000_0008;
   localparam logic [31:0] RX_STAT_OFS = 32'h0000_000C;
   localparam logic [31:0] CDA_RX_OFS = 32'h0000_0000;
   localparam logic [31:0] CDA_TX_OFS = 32'h0000_0004;
   localparam logic [31:0] INTQ_OFS = 32'h0000_0008;

   ////////////////////////////////////////////////////////////////////////////
   // control word fields
   localparam int unsigned CTRL_HOLD_BIT = 31;
   localparam int unsigned CTRL_FE_BIT = 30;
   localparam int unsigned CTRL_FILL_LSB = 16;
   localparam int unsigned CTRL_LEN_LSB = 0;
   localparam int unsigned INT_TX_BIT = 31;
   localparam int unsigned INT_FE_BIT = 30;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [3:0] BE_WORD = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hdma_op_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [3:0] be;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hdma_bus_out_type;

   typedef struct packed {
      logic gnt;
      logic ack;
      logic [31:0] rdata;
   } hdma_bus_in_type;

   // words needed for n packed bytes
   function automatic logic [WORDS_W-1:0] hdma_words(input logic [LEN_W-1:0] n);
      logic [LEN_W-1:0] nm1;
      nm1 = n - 13'h0001;
      if (n == '0) begin
         return '0;
      end
      return WORDS_W'(nm1 >> 2) + 11'h001;
   endfunction

endpackage

// ---- verilog/hdma_bus_unit.sv ----
// hdma_bus_unit: one-word bus master cycle with request, grant and acknowledge
`timescale 1ns/100ps
`default_nettype none
module hdma_bus_unit (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic op_valid_in,
   input wire hdma_pkg::hdma_op_type op_in,
   output var logic op_done_out,
   output var logic [31:0] op_rdata_out,
   output var hdma_pkg::hdma_bus_out_type bus_out,
   input wire hdma_pkg::hdma_bus_in_type bus_in
);
   import hdma_pkg::*;

   typedef enum logic [1:0] {U_IDLE, U_REQ, U_XFER} hdma_ustate_type;
   hdma_ustate_type ust_r;

   ////////////////////////////////////////////////////////////////////////////
   // request held until grant, address phase held until acknowledge
   always_ff @(posedge core_clk_in) begin
      op_done_out <= 1'b0;
      if (srst_in) begin
         ust_r <= U_IDLE;
         bus_out <= '0;
         op_rdata_out <= '0;
      end else begin
         unique case (ust_r)
            U_IDLE: if (op_valid_in) begin
               bus_out.req <= 1'b1; // [R13]
               ust_r <= U_REQ;
            end
            U_REQ: if (bus_in.gnt) begin
               bus_out.we <= op_in.we;
               bus_out.be <= BE_WORD; // [R4]
               bus_out.addr <= op_in.addr;
               bus_out.wdata <= op_in.wdata;
               ust_r <= U_XFER;
            end
            U_XFER: if (bus_in.ack) begin
               bus_out <= '0;
               op_rdata_out <= bus_in.rdata;
               op_done_out <= 1'b1;
               ust_r <= U_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_req_holds_ungranted: assert property (@(posedge core_clk_in) disable iff (srst_in) // [R13]
      (bus_out.req && !bus_in.gnt && ust_r == U_REQ) |=> bus_out.req)
      else $error("bus request dropped before grant");
   a_word_wide_cycle: assert property (@(posedge core_clk_in) disable iff (srst_in) // [R4]
      (ust_r == U_XFER) |-> (bus_out.be == 4'hF && bus_out.req))
      else $error("bus cycle is not a full word");
   a_done_after_ack: assert property (@(posedge core_clk_in) disable iff (srst_in) // [R13]
      op_done_out |-> $past(bus_in.ack) && !bus_out.req)
      else $error("access completed without acknowledge");

endmodule
`default_nettype wire

// ---- verilog/hdma_engine.sv ----
// hdma_engine: descriptor, data and write-back sequencing for one hdlc channel
`timescale 1ns/100ps
`default_nettype none
module hdma_engine (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic slot_in,
   input wire logic chan_cmd_valid_in,
   input wire logic transmit_hold_cmd_in,
   input wire logic [31:0] chan_cmd_rx_addr_in,
   input wire logic [31:0] chan_cmd_tx_addr_in,
   input wire logic [31:0] ctl_base_in,
   input wire logic rx_req_in,
   input wire logic [hdma_pkg::LEN_W-1:0] rx_len_in,
   input wire logic rx_frame_end_in,
   input wire logic [31:0] rx_word_in,
   output var logic rx_word_take_out,
   output var logic rx_done_out,
   output var logic [31:0] tx_word_out,
   output var logic tx_word_valid_out,
   output var logic tx_frame_end_out,
   output var logic [hdma_pkg::LEN_W:0] tx_frame_bytes_out,
   output var logic tx_idle_fill_out,
   output var logic tx_held_out,
   output var hdma_pkg::hdma_bus_out_type bus_out,
   input wire hdma_pkg::hdma_bus_in_type bus_in
);
   import hdma_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_RX_DESC, ST_RX_DATA, ST_RX_CDA, ST_RX_STAT, ST_RX_INT,
      ST_TX_DESC, ST_TX_DATA, ST_TX_CDA, ST_TX_INT
   } hdma_state_type;

   hdma_state_type state_r, state_nxt;
   logic busy_r, op_done;
   logic [31:0] op_rdata;
   hdma_op_type op;
   logic [WORDS_W-1:0] idx_r;
   logic [2:0] desc_ops_r;
   logic [WORDS_W-1:0] data_ops_r;
   logic [31:0] rx_desc_r, tx_desc_r, next_r, buf_r, ctrl_r;
   logic [LEN_W-1:0] rx_left_r, chunk_r;
   logic rx_pend_r, rx_fe_r, desc_hold_r, poll_due_r;
   logic [1:0] slot_cnt_r;
   logic [FILL_W:0] idle_left_r, idle_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // decode of the descriptor and of the access in flight
   wire is_tx = state_r inside {ST_TX_DESC, ST_TX_DATA, ST_TX_CDA, ST_TX_INT};
   wire is_data = state_r inside {ST_RX_DATA, ST_TX_DATA};
   wire [31:0] idx_ofs = {19'h0_0000, idx_r, 2'b00};
   wire [LEN_W-1:0] rd_len = op_rdata[CTRL_LEN_LSB +: LEN_W];
   wire [LEN_W-1:0] tx_len = ctrl_r[CTRL_LEN_LSB +: LEN_W];
   wire [FILL_W-1:0] idle_fill_count = ctrl_r[CTRL_FILL_LSB +: FILL_W];
   wire tx_fe = ctrl_r[CTRL_FE_BIT];
   wire [WORDS_W-1:0] data_words = hdma_words(chunk_r); // [R3]
   wire [LEN_W-1:0] rx_chunk = (rx_left_r > rd_len) ? rd_len : rx_left_r; // [R5]
   wire last_desc_rd = (idx_r == WORDS_W'(DESC_READS - 1));
   wire last_data = (idx_r == data_words - 11'h001);
   // a hold stops the transmit side at the next access boundary
   wire tx_abort = is_tx && tx_held_out && !busy_r; // [R7]
   wire op_start = (state_r != ST_IDLE) && !busy_r && !tx_abort;
   // idle fill and channel hold both keep the poll from starting
   wire poll_ok = poll_due_r && !tx_held_out && (idle_left_r == '0); // [R10] [R8]
   // frame end belongs only to the descriptor that holds the frame's last bytes
   wire rx_fe_last = rx_fe_r && (rx_left_r == chunk_r); // [R5]
   wire [31:0] int_word = {is_tx, is_tx ? tx_fe : rx_fe_last, 30'h0000_0000};

   ////////////////////////////////////////////////////////////////////////////
   // address and data of the next word access
   always_comb begin
      op = '0;
      unique case (state_r)
         ST_IDLE: op = '0;
         ST_RX_DESC: op = '{1'b0, rx_desc_r + idx_ofs, ZERO_WORD};
         ST_RX_DATA: op = '{1'b1, buf_r + idx_ofs, rx_word_in};
         ST_RX_CDA: op = '{1'b1, ctl_base_in + CDA_RX_OFS, rx_desc_r};
         ST_RX_STAT: op = '{1'b1, rx_desc_r + RX_STAT_OFS,
                            {rx_fe_last, 18'h0_0000, chunk_r}};
         ST_RX_INT: op = '{1'b1, ctl_base_in + INTQ_OFS, int_word};
         ST_TX_DESC: op = '{1'b0, tx_desc_r + idx_ofs, ZERO_WORD};
         ST_TX_DATA: op = '{1'b0, buf_r + idx_ofs, ZERO_WORD};
         ST_TX_CDA: op = '{1'b1, ctl_base_in + CDA_TX_OFS, tx_desc_r};
         ST_TX_INT: op = '{1'b1, ctl_base_in + INTQ_OFS, int_word};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequence: descriptor reads, data, write-backs
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: if (rx_pend_r) state_nxt = ST_RX_DESC;
            else if (poll_ok) state_nxt = ST_TX_DESC;
         ST_RX_DESC: if (op_done && last_desc_rd) begin
            state_nxt = (data_words != '0) ? ST_RX_DATA : ST_RX_CDA; // [R3]
         end
         ST_RX_DATA: if (op_done && last_data) state_nxt = ST_RX_CDA;
         ST_RX_CDA: if (op_done) state_nxt = ST_RX_STAT; // [R1]
         ST_RX_STAT: if (op_done) state_nxt = ST_RX_INT; // [R1]
         ST_RX_INT: if (op_done) state_nxt = ST_IDLE;
         ST_TX_DESC: if (tx_abort) state_nxt = ST_IDLE;
            else if (op_done && idx_r == '0 && op_rdata[CTRL_HOLD_BIT]) state_nxt = ST_IDLE;
            else if (op_done && last_desc_rd) begin
               state_nxt = (hdma_words(tx_len) != '0) ? ST_TX_DATA : ST_TX_CDA;
            end
         ST_TX_DATA: if (tx_abort) state_nxt = ST_IDLE;
            else if (op_done && last_data) state_nxt = ST_TX_CDA;
         ST_TX_CDA: if (tx_abort) state_nxt = ST_IDLE;
            else if (op_done) state_nxt = ST_TX_INT; // [R2]
         ST_TX_INT: if (tx_abort) state_nxt = ST_IDLE;
            else if (op_done) state_nxt = ST_IDLE;
      endcase
   end

   // idle characters count down one per channel slot
   always_comb begin
      idle_nxt = idle_left_r;
      if (slot_in && idle_left_r != '0) idle_nxt = idle_left_r - 9'h001;
      if (state_r == ST_TX_INT && op_done && tx_fe && idle_fill_count != '0) begin
         idle_nxt = {1'b0, idle_fill_count} + 9'h001; // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer registers
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_r <= ST_IDLE;
         busy_r <= 1'b0;
         idx_r <= '0;
         desc_ops_r <= '0;
         data_ops_r <= '0;
      end else begin
         state_r <= state_nxt;
         busy_r <= op_start | (busy_r & ~op_done);
         idx_r <= (state_nxt != state_r) ? '0 : (op_done ? idx_r + 11'h001 : idx_r);
         desc_ops_r <= (state_r == ST_IDLE) ? '0 : desc_ops_r + 3'(op_done & ~is_data);
         data_ops_r <= (state_r == ST_IDLE) ? '0 : data_ops_r + 11'(op_done & is_data);
      end
   end

   // descriptor contents and chain pointers
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         {rx_desc_r, tx_desc_r, next_r, buf_r, ctrl_r} <= '0;
         chunk_r <= '0;
      end else begin
         if (op_done && state_r inside {ST_RX_DESC, ST_TX_DESC}) begin
            if (idx_r == 11'h000) ctrl_r <= op_rdata;
            if (idx_r == 11'h001) next_r <= op_rdata;
            if (idx_r == 11'h002) buf_r <= op_rdata;
         end
         if (op_done && state_r == ST_RX_DESC && idx_r == 11'h000) chunk_r <= rx_chunk;
         if (op_done && state_r == ST_TX_DESC && idx_r == 11'h002) chunk_r <= tx_len;
         if (op_done && state_r == ST_RX_INT) rx_desc_r <= next_r;
         if (op_done && state_r == ST_TX_INT) tx_desc_r <= next_r;
         if (chan_cmd_valid_in) begin
            rx_desc_r <= chan_cmd_rx_addr_in;
            tx_desc_r <= chan_cmd_tx_addr_in;
         end
      end
   end

   // receive work, remainder carried into the next descriptor
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rx_pend_r <= 1'b0;
         rx_fe_r <= 1'b0;
         rx_left_r <= '0;
      end else if (rx_req_in && !rx_pend_r) begin
         rx_pend_r <= 1'b1;
         rx_left_r <= rx_len_in;
         rx_fe_r <= rx_frame_end_in;
      end else if (op_done && state_r == ST_RX_INT) begin
         rx_left_r <= rx_left_r - chunk_r;
         rx_pend_r <= (rx_left_r != chunk_r); // [R5]
      end
   end

   // transmit hold, descriptor hold and poll pacing
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         tx_held_out <= 1'b0;
         desc_hold_r <= 1'b0;
         poll_due_r <= 1'b0;
         slot_cnt_r <= '0;
         idle_left_r <= '0;
         tx_idle_fill_out <= 1'b0;
      end else begin
         if (chan_cmd_valid_in) tx_held_out <= transmit_hold_cmd_in; // [R7] [R8]
         if (op_done && state_r == ST_TX_DESC && idx_r == '0) begin
            desc_hold_r <= op_rdata[CTRL_HOLD_BIT];
         end
         if (slot_in) slot_cnt_r <= slot_cnt_r + 2'b01;
         // a slot landing on the poll start wins, so no due poll is lost
         if (slot_in && (desc_hold_r || slot_cnt_r == 2'(POLL_SLOTS - 1))) begin
            poll_due_r <= 1'b1; // [R11] [R12]
         end else if (state_r == ST_IDLE && state_nxt == ST_TX_DESC) begin
            poll_due_r <= 1'b0;
         end
         idle_left_r <= idle_nxt;
         tx_idle_fill_out <= (idle_nxt != '0);
      end
   end

   // serial side strobes; crc bytes are added here, never read from memory
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         {rx_word_take_out, rx_done_out, tx_word_valid_out, tx_frame_end_out} <= '0;
         tx_word_out <= '0;
         tx_frame_bytes_out <= '0;
      end else begin
         rx_word_take_out <= op_done && state_r == ST_RX_DATA;
         rx_done_out <= op_done && state_r == ST_RX_INT;
         tx_word_valid_out <= op_done && state_r == ST_TX_DATA;
         if (op_done && state_r == ST_TX_DATA) tx_word_out <= op_rdata;
         tx_frame_end_out <= op_done && state_r == ST_TX_INT && tx_fe;
         if (op_done && state_r == ST_TX_INT) begin
            tx_frame_bytes_out <= {1'b0, tx_len} + (tx_fe ? 14'(CRC_BYTES) : 14'h0000); // [R6]
         end
      end
   end

   hdma_bus_unit u_bus (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .op_valid_in(op_start),
      .op_in(op),
      .op_done_out(op_done),
      .op_rdata_out(op_rdata),
      .bus_out(bus_out),
      .bus_in(bus_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_fill_frame_end;
      state_r == ST_TX_INT && op_done && tx_fe && idle_fill_count != '0;
   endsequence

   a_rx_six_accesses: assert property ( // [R1]
      (state_r == ST_RX_INT && op_done) |-> desc_ops_r == 3'd5)
      else $error("receive descriptor access count wrong");
   a_tx_five_accesses: assert property ( // [R2]
      (state_r == ST_TX_INT && op_done) |-> desc_ops_r == 3'd4)
      else $error("transmit descriptor access count wrong");
   // a hold may cut the data phase short, so only a phase that runs on is counted
   a_data_word_count: assert property ( // [R3]
      ($fell(is_data) && state_r != ST_IDLE) |-> data_ops_r == data_words)
      else $error("data word count wrong");
   // watched on the bus: a transmit request launched while held is the leak
   a_hold_no_access: assert property ( // [R7]
      ($rose(bus_out.req) && $past(is_tx)) |-> !$past(tx_held_out))
      else $error("transmit access while channel held");
   a_fill_count_load: assert property ( // [R9]
      s_fill_frame_end |=> idle_left_r == $past(idle_fill_count) + 9'd1)
      else $error("idle fill length wrong");
   a_no_poll_in_fill: assert property ( // [R10]
      (idle_left_r != '0) |=> !(state_r == ST_TX_DESC && $changed(state_r)))
      else $error("descriptor polled during idle fill");
   a_held_desc_repoll: assert property ( // [R11]
      (desc_hold_r && slot_in && !tx_held_out) |=> poll_due_r)
      else $error("held descriptor not rearmed for this slot");
   a_poll_pacing: assert property ( // [R12]
      (!desc_hold_r && $rose(poll_due_r)) |-> $past(slot_cnt_r) == 2'd3)
      else $error("poll not paced to every fourth slot");
   a_crc_added: assert property ( // [R6]
      tx_frame_end_out |-> tx_frame_bytes_out == {1'b0, $past(tx_len, 2)} + 14'd2)
      else $error("crc bytes not added at frame end");

endmodule
`default_nettype wire

// ---- verif/hdma_mem_model.sv ----
// hdma_mem_model: behavioural shared memory bus with arbiter facing the engine
`timescale 1ns/100ps
`default_nettype none
module hdma_mem_model import hdma_pkg::*; (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic [3:0] gnt_wait_in,
   input wire hdma_pkg::hdma_bus_out_type bus_in,
   output var hdma_pkg::hdma_bus_in_type bus_out,
   output var logic [15:0] acc_cnt_out,
   output var logic [15:0] bad_be_cnt_out
);
   logic [31:0] mem [logic [31:0]];
   logic [3:0] wait_r;
   logic addr_ph;

   ////////////////////////////////////////////////////////////////////////////
   // address phase shows as nonzero byte enables; acked once, then released
   assign addr_ph = bus_in.req && (bus_in.be != 4'h0) && !bus_out.ack;

   // plain always so the bench may preload memory words between cycles
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         bus_out <= '0;
         wait_r <= '0;
         acc_cnt_out <= '0;
         bad_be_cnt_out <= '0;
      end else begin
         bus_out.ack <= addr_ph;
         bus_out.rdata <= ~bus_out.rdata; // released data inverts every cycle, so the cycle after the ack never shows the last word
         if (!bus_in.req) begin
            wait_r <= gnt_wait_in;
            bus_out.gnt <= 1'b0;
         end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
         end else begin
            bus_out.gnt <= 1'b1; // single master here, grant kept while requested
         end
         if (addr_ph) begin
            acc_cnt_out <= acc_cnt_out + 16'h0001;
            if (bus_in.be != BE_WORD) begin
               bad_be_cnt_out <= bad_be_cnt_out + 16'h0001;
            end
            if (bus_in.we) begin
               mem[bus_in.addr] = bus_in.wdata;
            end else begin
               bus_out.rdata <= mem.exists(bus_in.addr) ? mem[bus_in.addr] : 32'h0000_0000;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/hdma_engine_tb.sv ----
// hdma_engine_tb: scenario tasks for the descriptor engine against the memory model
`timescale 1ns/100ps
`default_nettype none
module hdma_engine_tb;
   import hdma_pkg::*;
   localparam logic [31:0] CTL = 32'h0000_8000;
   localparam int TIME_LIMIT = 20000;
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic slot = 1'b0;
   logic cmd_v = 1'b0;
   logic hold_cmd = 1'b0;
   logic rx_req = 1'b0;
   logic rx_fe = 1'b0;
   logic [31:0] rx_addr = 32'h0000_0000;
   logic [31:0] tx_addr = 32'h0000_0000;
   logic [LEN_W-1:0] rx_len = '0;
   logic [3:0] gnt_wait = 4'h0;
   logic take, rx_done, tx_v, tx_fe, fill, held;
   logic [31:0] rx_word, tx_word;
   logic [LEN_W:0] tx_bytes;
   hdma_bus_out_type bo;
   hdma_bus_in_type bi;
   logic [15:0] acc, bad_be, base_acc, base_fe;
   logic [15:0] idx = '0;
   logic [15:0] done_n = '0;
   logic [15:0] txw_n = '0;
   logic [15:0] fe_n = '0;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;

   always #12.5 core_clk_in = ~core_clk_in;
   // rx data source walks a numbered pattern, one word per take
   assign rx_word = {16'hA500, idx};

   hdma_engine dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .slot_in(slot),
      .chan_cmd_valid_in(cmd_v), .transmit_hold_cmd_in(hold_cmd),
      .chan_cmd_rx_addr_in(rx_addr), .chan_cmd_tx_addr_in(tx_addr), .ctl_base_in(CTL),
      .rx_req_in(rx_req), .rx_len_in(rx_len), .rx_frame_end_in(rx_fe), .rx_word_in(rx_word),
      .rx_word_take_out(take), .rx_done_out(rx_done), .tx_word_out(tx_word),
      .tx_word_valid_out(tx_v), .tx_frame_end_out(tx_fe), .tx_frame_bytes_out(tx_bytes),
      .tx_idle_fill_out(fill), .tx_held_out(held), .bus_out(bo), .bus_in(bi));
   hdma_mem_model mdl (.core_clk_in(core_clk_in), .srst_in(srst_in), .gnt_wait_in(gnt_wait),
      .bus_in(bo), .bus_out(bi), .acc_cnt_out(acc), .bad_be_cnt_out(bad_be));

   ////////////////////////////////////////////////////////////////////////////
   // pulse counters off the falling edge, where the registered pulses are settled
   always @(negedge core_clk_in) begin
      idx <= idx + {15'h0000, take};
      done_n <= done_n + {15'h0000, rx_done};
      txw_n <= txw_n + {15'h0000, tx_v};
      fe_n <= fe_n + {15'h0000, tx_fe};
   end
   // hang guard: a run this long means a wait never ended
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == TIME_LIMIT) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input string what);
      chk_word({16'h0000, got}, {16'h0000, exp}, what);
   endtask
   // missing words read back unknown so they can never match
   function automatic logic [31:0] rd(input logic [31:0] a);
      return mdl.mem.exists(a) ? mdl.mem[a] : 32'hxxxx_xxxx;
   endfunction
   task automatic put_desc(input logic [31:0] a, w0, w1, w2);
      mdl.mem[a] = w0;
      mdl.mem[a + 32'h0000_0004] = w1;
      mdl.mem[a + 32'h0000_0008] = w2;
   endtask
   // slot gap leaves room for a whole descriptor before the next slot
   task automatic slots(input int n);
      repeat (n) begin
         @(negedge core_clk_in);
         slot = 1'b1;
         @(negedge core_clk_in);
         slot = 1'b0;
         repeat (80) @(negedge core_clk_in);
      end
   endtask
   task automatic chan_cmd(input logic hold, input logic [31:0] rxa, txa);
      @(negedge core_clk_in);
      cmd_v = 1'b1;
      hold_cmd = hold;
      rx_addr = rxa;
      tx_addr = txa;
      @(negedge core_clk_in);
      cmd_v = 1'b0;
   endtask
   task automatic rx_work(input logic [LEN_W-1:0] len, input logic [15:0] dones);
      @(negedge core_clk_in);
      rx_req = 1'b1;
      rx_len = len;
      rx_fe = 1'b1;
      @(negedge core_clk_in);
      rx_req = 1'b0;
      for (int i = 0; i < 400 && done_n < dones; i++) @(negedge core_clk_in);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_rx_single();
      base_acc = acc;
      put_desc(32'h0000_0100, 32'h0000_0020, 32'h0000_0200, 32'h0000_1000);
      rx_work(13'h0005, 16'h0001);
      chk_cnt(acc - base_acc, 16'h0008, "rx accesses");
      chk_cnt(bad_be, 16'h0000, "byte enables");
      chk_word(rd(32'h0000_1004), 32'hA500_0001, "rx data");
      chk_word(rd(32'h0000_010C), 32'h8000_0005, "rx status");
      chk_word(rd(CTL), 32'h0000_0100, "rx cda");
      chk_word(rd(CTL + 32'h0000_0008), 32'h4000_0000, "rx interrupt");
   endtask
   task automatic t_rx_span();
      gnt_wait = 4'h3;
      base_acc = acc;
      put_desc(32'h0000_0200, 32'h0000_0020, 32'h0000_0240, 32'h0000_1100);
      put_desc(32'h0000_0240, 32'h0000_0020, 32'h0000_0280, 32'h0000_1200);
      rx_work(13'h0028, 16'h0003);
      chk_cnt(acc - base_acc, 16'h0016, "spanning accesses");
      chk_word(rd(32'h0000_020C), 32'h0000_0020, "first status");
      chk_word(rd(32'h0000_024C), 32'h8000_0008, "last status");
      chk_word(rd(32'h0000_1204), 32'hA500_000B, "continued data");
      chk_cnt(done_n, 16'h0003, "rx done count");
   endtask
   task automatic t_tx_frame();
      gnt_wait = 4'h0;
      put_desc(32'h0000_0300, 32'h4000_0006, 32'h0000_0340, 32'h0000_2000);
      put_desc(32'h0000_0340, 32'h8000_0000, 32'h0000_0380, 32'h0000_2100);
      mdl.mem[32'h0000_2000] = 32'h1111_2222;
      mdl.mem[32'h0000_2004] = 32'h3333_4444;
      chan_cmd(1'b0, 32'h0000_0280, 32'h0000_0300);
      base_acc = acc;
      slots(4);
      chk_cnt(acc - base_acc, 16'h0007, "tx accesses");
      chk_cnt(txw_n, 16'h0002, "tx words");
      chk_word(tx_word, 32'h3333_4444, "last tx word");
      chk_cnt({2'b00, tx_bytes}, 16'h0008, "frame bytes");
      chk_cnt(fe_n, 16'h0001, "frame end");
      chk_word(rd(CTL + 32'h0000_0004), 32'h0000_0300, "tx cda");
      chk_word(rd(CTL + 32'h0000_0008), 32'hC000_0000, "tx interrupt");
   endtask
   task automatic t_tx_desc_hold();
      slots(4);
      base_acc = acc;
      slots(3);
      chk_cnt(acc - base_acc, 16'h0003, "held polls");
      chk_word({31'h0000_0000, held}, 32'h0000_0000, "command hold");
      put_desc(32'h0000_0340, 32'h4004_0004, 32'h0000_0380, 32'h0000_2100);
      put_desc(32'h0000_0380, 32'h8000_0000, 32'h0000_0380, 32'h0000_2100);
      mdl.mem[32'h0000_2100] = 32'h5555_6666;
      base_acc = acc;
      slots(1);
      chk_cnt(acc - base_acc, 16'h0006, "resumed frame");
      chk_word({31'h0000_0000, fill}, 32'h0000_0001, "fill on");
      base_acc = acc;
      slots(4);
      chk_cnt(acc - base_acc, 16'h0000, "polls in fill");
      chk_word({31'h0000_0000, fill}, 32'h0000_0001, "fill on");
      slots(1);
      chk_word({31'h0000_0000, fill}, 32'h0000_0000, "fill off");
   endtask
   task automatic t_cmd_hold();
      put_desc(32'h0000_0400, 32'h4000_0004, 32'h0000_0440, 32'h0000_2200);
      put_desc(32'h0000_0440, 32'h8000_0000, 32'h0000_0440, 32'h0000_2200);
      mdl.mem[32'h0000_2200] = 32'h7777_8888;
      chan_cmd(1'b1, 32'h0000_0280, 32'h0000_0400);
      chk_word({31'h0000_0000, held}, 32'h0000_0001, "held");
      base_acc = acc;
      slots(8);
      chk_cnt(acc - base_acc, 16'h0000, "accesses while held");
      chan_cmd(1'b0, 32'h0000_0280, 32'h0000_0400);
      chk_word({31'h0000_0000, held}, 32'h0000_0000, "released");
      base_fe = fe_n;
      slots(4);
      chk_cnt(fe_n - base_fe, 16'h0001, "frame after release");
      chk_word(tx_word, 32'h7777_8888, "tx word after release");
      chk_word(rd(CTL + 32'h0000_0004), 32'h0000_0400, "cda after release");
   endtask

   initial begin
      repeat (10) @(negedge core_clk_in);
      srst_in = 1'b0;
      chan_cmd(1'b0, 32'h0000_0100, 32'h0000_0300);
      t_rx_single();
      t_rx_span();
      t_tx_frame();
      t_tx_desc_hold();
      t_cmd_hold();
      stop_test();
   end
endmodule
`default_nettype wire
